// ==== smcp_consts.vh ====
`ifndef SMCP_CONSTS_VH
`define SMCP_CONSTS_VH
`define SMCP_ADDR_PREFIX    4'h8
`define SMCP_CMD_WRITE_CONFIG    8'h01
`define SMCP_CMD_READ_CONFIG     8'h02
`define SMCP_CMD_READ_CELL_VOLT  8'h04
`define SMCP_CMD_READ_FLAGS      8'h06
`define SMCP_CMD_READ_TEMP       8'h08
`define SMCP_CMD_POLL_ADC   8'h40
`define SMCP_CMD_POLL_INT   8'h50
`define SMCP_FAM_CELL       4'h1
`define SMCP_FAM_OPEN       4'h2
`define SMCP_FAM_TEMP       4'h3
`define SMCP_FAM_CELL_DC    4'h6
`define SMCP_FAM_OPEN_DC    4'h7
`define SMCP_SUB_UNUSED     4'hd
`define SMCP_SUB_CELL11     4'hb
`define SMCP_SUB_CELL12     4'hc
`define SMCP_SUB_TEMP_LAST  4'h3
`define SMCP_SUB_TEST1      4'he
`define SMCP_SUB_TEST2      4'hf
`define SMCP_CRC_POLY       8'h07
`define SMCP_CRC_INIT       8'h00
`define SMCP_CFG_BYTES      5'd6
`define SMCP_CV_BYTES       5'd18
`define SMCP_CV10_BYTES     5'd15
`define SMCP_FLG_BYTES      5'd3
`define SMCP_TMP_BYTES      5'd5
`define SMCP_CLK_HZ         25000000
`define SMCP_TOGGLE_HZ      1000
`define SMCP_HALF_CYC       (`SMCP_CLK_HZ / (2 * `SMCP_TOGGLE_HZ))
`define SMCP_CFG_LEVEL_POLL_BIT 4
`define SMCP_CFG_TEN_CELL_BIT   3
`endif

// ==== smcp_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// master controller model for the mode 1,1 link; 320 ns link clock
module smcp_master (
  input  wire logic mclk_i,
  input  wire logic serial_data_out_i,
  output var  logic cs_b_o,
  output var  logic serial_clock_in_o,
  output var  logic serial_data_in_o
);
  // clock idles high and stands still between frames
  initial begin
    cs_b_o            = 1'b1;
    serial_clock_in_o = 1'b1;
    serial_data_in_o  = 1'b0;
  end
  // half a link clock, landing on falling mclk edges
  task automatic half();
    repeat (4) @(negedge mclk_i);
  endtask
  // select; held low through the whole sequence, alone on data-out
  task automatic open();
    @(negedge mclk_i);
    cs_b_o = 1'b0;
    half();
  endtask
  // deselect commits writes and ends polls; gap covers the synchroniser
  task automatic shut();
    half();
    cs_b_o = 1'b1;
    repeat (8) @(negedge mclk_i);
  endtask
  // msb first: drive on the falling clock, sample on the rising clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int k = 7; k >= 0; k--) begin
      serial_clock_in_o = 1'b0;
      serial_data_in_o  = tx[k];
      half();
      serial_clock_in_o = 1'b1;
      rx[k] = serial_data_out_i;
      // garble data mid-high: a device sampling late would catch it
      repeat (2) @(negedge mclk_i);
      serial_data_in_o = ~serial_data_in_o;
      repeat (2) @(negedge mclk_i);
    end
  endtask
endmodule // smcp_master
`default_nettype wire

// ==== smcp_mem.v ====
`timescale 1ns/1ps
`default_nettype none
// small register-group memory; read data comes out of a register
module smcp_mem #(
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire          mclk_i,
  input  wire          ce_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [7:0]    wdata_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [7:0]    rdata_o
);
  reg [7:0] mem [0:DEPTH-1];  // byte storage, no reset needed
  // one write port, one registered read port
  always @(posedge mclk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // smcp_mem
`default_nettype wire

// ==== smcp_port.v ====
// Operation
// RQ1 - broadcast commands accepted regardless of address
// RQ2 - addressed command: 1000 prefix, address, command
// RQ3 - only matching address responds; others ignore
// RQ4 - CRC-8 x^8+x^2+x+1 over group bits
// RQ5 - CRC byte follows group, MSB first
// RQ6 - level-poll bit selects toggle or level
// RQ7 - toggle style: low busy, else 1kHz
// RQ8 - addressed toggle poll uses own state only
// RQ9 - broadcast toggle: idle releases unless top device
// RQ10 - chip-select high ends poll drive
// RQ11 - level style: low busy, high idle
// RQ12 - addressed level poll: low or released
// RQ13 - broadcast level poll: low or released
// RQ14 - after start command, report status until deselect
// RQ15 - 0x40 polls converter status
// RQ16 - 0x50 polls interrupt status
// RQ17 - 0x01 writes config, 0x02 reads it
// RQ18 - 0x04/0x06/0x08 read cell, flag, temp
// RQ19 - cell conversion codes 0x10-0x1F decoded
// RQ20 - open-wire codes 0x20-0x2F same nibbles
// RQ21 - temperature codes 0x30-0x3F decoded
// RQ22 - 0x6x/0x7x allow discharge during conversion
// RQ23 - mode 1,1: sample rising, shift falling
// RQ24 - chip-select low throughout; writes commit rising
// RQ25 - read: data low-to-high then CRC
// RQ26 - master avoids broadcast reads in parallel
`timescale 1ns/1ps
`default_nettype none
`include "smcp_consts.vh"
module smcp_port #(
  parameter HALF_CYC = `SMCP_HALF_CYC  // cycles per half of the 1kHz toggle
) (
  input  wire        mclk_i,
  input  wire        rst_b_i,
  input  wire        ce_i,
  input  wire        chip_select_in_b_i,  // active low chip select pin
  input  wire        serial_clock_in_i,
  input  wire        serial_data_in_i,
  input  wire [3:0]  part_addr_i,         // address pins
  input  wire        top_of_stack_sel_i,
  input  wire        adc_busy_i,          // converter busy
  input  wire        interrupt_i,         // ov/uv interrupt present
  input  wire        grp_wr_i,            // engine loads a result byte
  input  wire [4:0]  grp_wr_addr_i,       // 0-17 cell, 18-20 flag, 21-25 temp
  input  wire [7:0]  grp_wr_data_i,
  output reg         serial_data_out_o,
  output reg         serial_data_out_oe_o,
  output reg  [47:0] config_o,            // committed configuration group
  output reg         cfg_strobe_o,        // one-cycle pulse on commit
  output reg         conv_start_o,        // one-cycle pulse
  output reg  [7:0]  conv_cmd_o,          // accepted conversion code
  output reg         conv_discharge_o,
  output reg         conv_self_test_o,
  output reg  [11:0] conv_test_pattern_o
);
  localparam CW = 32;
  localparam [CW-1:0] HALF = HALF_CYC - 1;
  // one-hot states
  localparam [5:0] S_IDLE = 6'h01, S_HDR = 6'h02, S_CMD = 6'h04,
                   S_WR = 6'h08, S_RD = 6'h10, S_POLL = 6'h20;
  localparam [1:0] P_ADC = 2'h1, P_INT = 2'h2;
  // crc step over one bit, msb-first
  function [7:0] crc_bit;
    input [7:0] c;
    input       b;
    begin
      crc_bit = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `SMCP_CRC_POLY : 8'h00);
    end
  endfunction
  // two-flop synchronisers for pins
  reg [1:0] cs_s_q, sck_s_q, sdi_s_q, top_s_q;
  reg [7:0] addr_s_q;      // address pins, two stages of four
  reg       sck_d_q;       // delayed synced clock for edge finding
  reg       cs_d_q;
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_s_q  <= 2'h3;
      sck_s_q <= 2'h3;
      sdi_s_q <= 2'h0;
      top_s_q <= 2'h0;
      addr_s_q <= 8'h00;
      sck_d_q <= 1'b1;
      cs_d_q  <= 1'b1;
    end else if (ce_i) begin
      cs_s_q  <= {cs_s_q[0], chip_select_in_b_i};
      sck_s_q <= {sck_s_q[0], serial_clock_in_i};
      sdi_s_q <= {sdi_s_q[0], serial_data_in_i};
      top_s_q <= {top_s_q[0], top_of_stack_sel_i};
      addr_s_q <= {addr_s_q[3:0], part_addr_i};
      sck_d_q <= sck_s_q[1];
      cs_d_q  <= cs_s_q[1];
    end
  end
  wire cs_b   = cs_s_q[1];
  wire sck_r  = sck_s_q[1] & ~sck_d_q;  // sample edge [RQ23]
  wire sck_f  = ~sck_s_q[1] & sck_d_q;  // shift edge [RQ23]
  wire cs_rise = cs_b & ~cs_d_q;
  reg  [5:0]  st_q;
  reg  [7:0]  sh_q;          // receive shifter
  reg  [2:0]  bit_q;
  reg         bcast_q;       // command arrived without address byte
  reg  [7:0]  tx_q;          // transmit shifter
  reg  [4:0]  rd_ptr_q;      // memory byte index
  reg  [4:0]  rd_left_q;     // data bytes left to load, crc slot not counted
  reg         crc_slot_q;
  reg  [7:0]  crc_q;
  reg  [2:0]  wr_cnt_q;
  reg  [47:0] cfg_stage_q;   // staged write data
  reg  [1:0]  poll_kind_q;
  reg  [CW-1:0] tog_cnt_q;
  reg         tog_q;
  reg         load_q;        // memory read issued, load tx next
  wire [7:0]  mem_rd;
  wire [7:0]  rx_byte = {sh_q[6:0], sdi_s_q[1]};
  wire        byte_done = sck_r & (bit_q == 3'h7);
  wire        ten_cell_sel = config_o[`SMCP_CFG_TEN_CELL_BIT];
  // decode of a command byte
  wire [3:0] fam = rx_byte[7:4];
  wire [3:0] sub = rx_byte[3:0];
  wire is_cellfam = (fam == `SMCP_FAM_CELL) | (fam == `SMCP_FAM_OPEN) |
                    (fam == `SMCP_FAM_CELL_DC) | (fam == `SMCP_FAM_OPEN_DC);
  // valid start codes: unused and 10-cell-masked cells dropped [RQ19] [RQ20] [RQ22]
  wire cell_ok = is_cellfam & (sub != `SMCP_SUB_UNUSED) &
                 ~(ten_cell_sel & ((sub == `SMCP_SUB_CELL11) | (sub == `SMCP_SUB_CELL12)));
  // temperature codes: 0-3 and self tests, rest unused [RQ21]
  wire temp_ok = (fam == `SMCP_FAM_TEMP) &
                 ((sub <= `SMCP_SUB_TEMP_LAST) | (sub >= `SMCP_SUB_TEST1));
  wire start_ok = cell_ok | temp_ok;
  // group base index and length in memory
  reg [4:0] g_base, g_len;
  reg       g_rd;
  always @* begin
    g_base = 5'h00;
    g_len  = 5'h00;
    g_rd   = 1'b1;
    case (rx_byte) // [RQ18]
      `SMCP_CMD_READ_CELL_VOLT: g_len = ten_cell_sel ? `SMCP_CV10_BYTES : `SMCP_CV_BYTES;
      `SMCP_CMD_READ_FLAGS: begin
        g_base = `SMCP_CV_BYTES;
        g_len  = `SMCP_FLG_BYTES;
      end
      `SMCP_CMD_READ_TEMP: begin
        g_base = `SMCP_CV_BYTES + `SMCP_FLG_BYTES;
        g_len  = `SMCP_TMP_BYTES;
      end
      default: g_rd = 1'b0;
    endcase
  end
  wire cfg_rd = (rx_byte == `SMCP_CMD_READ_CONFIG);  // [RQ17]
  // the group base is fetched while the command decodes, so the registered
  // read already holds the first byte when the shifter loads it
  wire [4:0] mem_raddr = (st_q == S_RD) ? rd_ptr_q : g_base;
  smcp_mem #(.DEPTH(32), .AW(5)) u_mem (
    .mclk_i  (mclk_i),
    .ce_i    (ce_i),
    .we_i    (grp_wr_i),
    .waddr_i (grp_wr_addr_i),
    .wdata_i (grp_wr_data_i),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rd)
  );
  reg cfg_src_q;  // read source is config group
  wire [7:0] cfg_byte = config_o[rd_ptr_q[2:0]*8 +: 8];
  wire [7:0] next_byte = cfg_src_q ? cfg_byte : mem_rd;
  wire own_state = (poll_kind_q == P_ADC) ? adc_busy_i : interrupt_i;
  // main sequencer
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= S_IDLE; sh_q <= 8'h00; bit_q <= 3'h0; bcast_q <= 1'b1;
      tx_q <= 8'hff; rd_ptr_q <= 5'h00; rd_left_q <= 5'h00;
      crc_slot_q <= 1'b0; crc_q <= `SMCP_CRC_INIT; wr_cnt_q <= 3'h0;
      cfg_stage_q <= 48'h0; poll_kind_q <= 2'h0; load_q <= 1'b0;
      cfg_src_q <= 1'b0; config_o <= 48'h0; cfg_strobe_o <= 1'b0;
      conv_start_o <= 1'b0; conv_cmd_o <= 8'h00; conv_discharge_o <= 1'b0;
      conv_self_test_o <= 1'b0; conv_test_pattern_o <= 12'h000;
    end else if (ce_i) begin
      cfg_strobe_o <= 1'b0;
      conv_start_o <= 1'b0;
      if (cs_b) begin
        // deselect ends any phase; writes commit on the rising edge [RQ10] [RQ24]
        if (cs_rise && st_q == S_WR && wr_cnt_q == `SMCP_CFG_BYTES) begin
          config_o     <= cfg_stage_q;
          cfg_strobe_o <= 1'b1;
        end
        st_q  <= S_IDLE;
        bit_q <= 3'h0;
      end else begin
        if (sck_r) begin
          sh_q  <= rx_byte;
          bit_q <= bit_q + 3'h1;
        end
        case (st_q)
          S_IDLE: begin
            st_q    <= S_HDR;
            bcast_q <= 1'b1;
          end
          S_HDR, S_CMD: if (byte_done) begin
            if (st_q == S_HDR && rx_byte[7:4] == `SMCP_ADDR_PREFIX) begin
              bcast_q <= 1'b0;  // [RQ2]
              // foreign address: sit silently until deselect [RQ3]
              st_q <= (rx_byte[3:0] == addr_s_q[7:4]) ? S_CMD : S_POLL;
              poll_kind_q <= 2'h0;
            end else if (rx_byte == `SMCP_CMD_WRITE_CONFIG) begin
              st_q <= S_WR;  // [RQ17]
              wr_cnt_q <= 3'h0;
            end else if (g_rd | cfg_rd) begin
              // read setup; broadcast reads also answered [RQ1] [RQ26]
              st_q <= S_RD;
              cfg_src_q <= cfg_rd;
              rd_ptr_q <= g_base;
              rd_left_q <= cfg_rd ? `SMCP_CFG_BYTES : g_len;
              crc_slot_q <= 1'b0;
              crc_q <= `SMCP_CRC_INIT;
              load_q <= 1'b1;
            end else if (rx_byte == `SMCP_CMD_POLL_ADC) begin
              st_q <= S_POLL;  // [RQ15]
              poll_kind_q <= P_ADC;
            end else if (rx_byte == `SMCP_CMD_POLL_INT) begin
              st_q <= S_POLL;  // [RQ16]
              poll_kind_q <= P_INT;
            end else if (start_ok) begin
              // start, then report converter status until deselect [RQ14]
              conv_start_o     <= 1'b1;
              conv_cmd_o       <= rx_byte;
              conv_discharge_o <= (fam == `SMCP_FAM_CELL_DC) | (fam == `SMCP_FAM_OPEN_DC);
              conv_self_test_o <= (sub == `SMCP_SUB_TEST1) | (sub == `SMCP_SUB_TEST2);
              conv_test_pattern_o <= (sub == `SMCP_SUB_TEST1) ? 12'h555 : 12'haaa;
              st_q <= S_POLL;
              poll_kind_q <= P_ADC;
            end else begin
              st_q <= S_POLL;  // unknown: ignore rest
              poll_kind_q <= 2'h0;
            end
          end
          S_WR: if (byte_done && wr_cnt_q != `SMCP_CFG_BYTES) begin
            // data byte low first, staged until commit [RQ25]
            cfg_stage_q[wr_cnt_q*8 +: 8] <= rx_byte;
            wr_cnt_q <= wr_cnt_q + 3'h1;
          end
          S_RD: begin
            if (load_q) begin
              // fetched byte or crc enters the shifter
              load_q <= 1'b0;
              tx_q <= crc_slot_q ? crc_q : next_byte;  // [RQ5]
              if (!crc_slot_q) begin
                crc_q <= crc_bit(crc_bit(crc_bit(crc_bit(crc_bit(crc_bit(
                         crc_bit(crc_bit(crc_q, next_byte[7]), next_byte[6]),
                         next_byte[5]), next_byte[4]), next_byte[3]),
                         next_byte[2]), next_byte[1]), next_byte[0]);  // [RQ4]
                rd_ptr_q <= rd_ptr_q + 5'h01;
                rd_left_q <= rd_left_q - 5'h01;
              end
            end else if (byte_done) begin
              // next byte low to high, crc after last [RQ25]
              if (crc_slot_q) begin
                st_q <= S_POLL;
                poll_kind_q <= 2'h0;
              end else begin
                crc_slot_q <= (rd_left_q == 5'h00);
                load_q <= 1'b1;
              end
            end else if (sck_f && bit_q != 3'h0) begin
              tx_q <= {tx_q[6:0], 1'b1};  // shift on falling edge [RQ23]
            end
          end
          S_POLL: ;
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
  // 1kHz toggle source
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tog_cnt_q <= {CW{1'b0}};
      tog_q     <= 1'b1;
    end else if (ce_i) begin
      if (tog_cnt_q >= HALF) begin
        tog_cnt_q <= {CW{1'b0}};
        tog_q     <= ~tog_q;
      end else begin
        tog_cnt_q <= tog_cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
  // output pin drive
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_data_out_o    <= 1'b1;
      serial_data_out_oe_o <= 1'b0;
    end else if (ce_i) begin
      serial_data_out_o    <= 1'b1;
      serial_data_out_oe_o <= 1'b0;
      if (!cs_b && st_q == S_RD && !load_q) begin
        serial_data_out_o    <= tx_q[7];
        serial_data_out_oe_o <= 1'b1;
      end else if (!cs_b && st_q == S_POLL && poll_kind_q != 2'h0) begin  // [RQ10]
        if (own_state) begin
          serial_data_out_o    <= 1'b0;  // busy pulls low [RQ7] [RQ11]
          serial_data_out_oe_o <= 1'b1;
        end else if (!config_o[`SMCP_CFG_LEVEL_POLL_BIT]) begin  // [RQ6]
          // toggle; broadcast idle non-top releases [RQ8] [RQ9]
          serial_data_out_o    <= tog_q;
          serial_data_out_oe_o <= ~bcast_q | top_s_q[1];
        end
        // level idle releases; pull-up gives high [RQ12] [RQ13]
      end
    end
  end
endmodule // smcp_port
`default_nettype wire

// ==== smcp_port_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the command port; sees only its pins
module smcp_port_chk #(
  parameter HALF_CYC = 12500  // toggle half period, handed on from the design
) (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        chip_select_in_b_i,
  input wire logic        adc_busy_i,
  input wire logic        serial_data_out_o,
  input wire logic        serial_data_out_oe_o,
  input wire logic [47:0] config_o,
  input wire logic        cfg_strobe_o,
  input wire logic        conv_start_o,
  input wire logic [7:0]  conv_cmd_o,
  input wire logic        conv_discharge_o,
  input wire logic        conv_self_test_o,
  input wire logic [11:0] conv_test_pattern_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  wire [3:0] fam = conv_cmd_o[7:4];  // command family nibble
  wire [3:0] sub = conv_cmd_o[3:0];  // channel or test nibble
  // deselected long enough to pass the two-flop synchroniser
  sequence idle_s;
    chip_select_in_b_i [*6];
  endsequence
  // a start while the frame stays open and the converter works
  sequence busy_s;
    conv_start_o ##1 (adc_busy_i && !chip_select_in_b_i) [*5];
  endsequence
  chk_poll_release: assert property (idle_s |-> !serial_data_out_oe_o)
    else $error("data-out still driven after deselect");
  chk_busy_low: assert property (busy_s |->
    serial_data_out_oe_o && !serial_data_out_o)
    else $error("busy converter not reported low");
  chk_strobe_pulse: assert property (cfg_strobe_o |=> !cfg_strobe_o)
    else $error("commit strobe longer than one cycle");
  chk_commit_deselected: assert property (cfg_strobe_o |-> chip_select_in_b_i)
    else $error("config committed while selected");
  chk_config_hold: assert property ($changed(config_o) |->
    cfg_strobe_o || $past(cfg_strobe_o))
    else $error("config changed without a commit");
  chk_start_frame: assert property (conv_start_o |-> !chip_select_in_b_i ##1 !conv_start_o)
    else $error("start pulse outside a frame or too long");
  chk_code_legal: assert property (conv_start_o |-> sub != 4'hd
    && fam inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7} && (fam != 4'h3 || sub < 4'h4 || sub > 4'hd))
    else $error("start issued for an unused code");
  chk_self_test: assert property (conv_start_o |->
    conv_self_test_o == (sub >= 4'he) && (sub != 4'he || conv_test_pattern_o == 12'h555)
    && (sub != 4'hf || conv_test_pattern_o == 12'haaa))
    else $error("self test flag or pattern wrong");
  chk_discharge_fam: assert property (conv_start_o |->
    conv_discharge_o == (fam[2:1] == 2'b11))
    else $error("discharge permission wrong for family");
endmodule // smcp_port_chk
bind smcp_port smcp_port_chk #(.HALF_CYC(HALF_CYC)) i_smcp_port_chk (.mclk_i(mclk_i),
  .rst_b_i(rst_b_i), .chip_select_in_b_i(chip_select_in_b_i), .adc_busy_i(adc_busy_i),
  .serial_data_out_o(serial_data_out_o), .serial_data_out_oe_o(serial_data_out_oe_o),
  .config_o(config_o), .cfg_strobe_o(cfg_strobe_o), .conv_start_o(conv_start_o),
  .conv_cmd_o(conv_cmd_o), .conv_discharge_o(conv_discharge_o),
  .conv_self_test_o(conv_self_test_o), .conv_test_pattern_o(conv_test_pattern_o));
`default_nettype wire

// ==== smcp_port_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// self-checking bench: driver notes expectations, monitors compare
module smcp_port_test;
  localparam int HC = 8;           // short toggle half period for sim
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        top_of_stack_sel = 1'b1;
  logic        hold_busy = 1'b0;   // forces busy for level polls
  logic        intr = 1'b0;
  logic        gw = 1'b0;
  logic [4:0]  ga = 5'h00;
  logic [7:0]  gd = 8'h00;
  logic [7:0]  mem [0:31];         // 0-25 result bytes, 26-31 config
  logic [47:0] exp_q [$];
  logic [47:0] got_v;
  logic [47:0] cfgv;
  logic [31:0] seed = 32'd53734;
  int          bcnt = 0;
  int          num_errors = 0;
  int          n_compared = 0;
  event        got_ev;
  logic [8:0]  codes [0:8] = '{9'h110, 9'h11e, 9'h12f, 9'h13e, 9'h160, 9'h17b,
                               9'h133, 9'h01d, 9'h034};  // bit8: start expected
  wire         chip_select_in_b, serial_clock_in, serial_data_in, serial_data_out;
  wire         oe, strobe, cstart;
  wire [47:0]  cfg;
  wire [7:0]   ccmd;
  wire         line = oe ? serial_data_out : 1'b1;  // pull-up on shared data-out
  wire         busy = hold_busy || (bcnt != 0);
  smcp_port #(.HALF_CYC(HC)) i_smcp_port (.mclk_i(mclk), .rst_b_i(rst_b), .ce_i(1'b1),
    .chip_select_in_b_i(chip_select_in_b), .serial_clock_in_i(serial_clock_in),
    .serial_data_in_i(serial_data_in), .part_addr_i(4'h5),
    .top_of_stack_sel_i(top_of_stack_sel), .adc_busy_i(busy), .interrupt_i(intr),
    .grp_wr_i(gw), .grp_wr_addr_i(ga), .grp_wr_data_i(gd),
    .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(oe), .config_o(cfg),
    .cfg_strobe_o(strobe), .conv_start_o(cstart), .conv_cmd_o(ccmd),
    .conv_discharge_o(), .conv_self_test_o(), .conv_test_pattern_o());
  smcp_master i_smcp_master (.mclk_i(mclk), .serial_data_out_i(line),
    .cs_b_o(chip_select_in_b), .serial_clock_in_o(serial_clock_in),
    .serial_data_in_o(serial_data_in));
  always #20 mclk = ~mclk;
  // converter model: busy for 20 cycles after each start
  always @(negedge mclk) bcnt <= cstart ? 20 : (bcnt > 0 ? bcnt - 1 : 0);
  // compare the oldest note against whatever result appears
  task automatic check(input logic [47:0] v);
    logic [47:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 'x;
    n_compared++;
    if (e !== v) begin
      num_errors++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, v);
    end
  endtask
  always @(got_ev) check(got_v);
  // pulses are looked at mid-cycle, well after the edge that launched them
  always @(negedge mclk) begin
    if (strobe === 1'b1) check(cfg);
    if (cstart === 1'b1) check({40'h0, ccmd});
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one step of the x^8+x^2+x+1 code, msb first
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    for (int k = 7; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[k]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic send(input logic [7:0] b);
    logic [7:0] r;
    i_smcp_master.xfer(b, r);
  endtask
  task automatic rdb(input logic [7:0] e);
    logic [7:0] r;
    exp_q.push_back({40'h0, e});
    i_smcp_master.xfer(8'h00, r);
    got_v = {40'h0, r};
    -> got_ev;
  endtask
  // open a frame, optional address byte, then the command byte
  task automatic hdr(input logic adr, input logic [3:0] a, input logic [7:0] cmd);
    i_smcp_master.open();
    if (adr) send({4'h8, a});
    send(cmd);
  endtask
  task automatic rdgrp(input logic adr, input logic [7:0] cmd, input int base, input int n);
    logic [7:0] c;
    c = 8'h00;
    hdr(adr, 4'h5, cmd);
    for (int i = 0; i < n; i++) begin
      c = crc(c, mem[base+i]);
      rdb(mem[base+i]);
    end
    rdb(c);
    i_smcp_master.shut();
    $display("test read %h finished", cmd);
  endtask
  // broadcast write of a random group; ten-cell bit kept clear
  task automatic write_config_cmd(input logic lvl);
    logic [31:0] r;
    r = xs();
    cfgv = {r, r[31:16] ^ 16'h5a3c};
    cfgv[4:3] = {lvl, 1'b0};
    exp_q.push_back(cfgv);
    hdr(1'b0, 4'h0, 8'h01);
    for (int i = 0; i < 6; i++) begin
      send(cfgv[8*i+:8]);
      mem[26+i] = cfgv[8*i+:8];
    end
    i_smcp_master.shut();
  endtask
  // note {drive enable, line} after the line has settled
  task automatic sample(input logic [1:0] e);
    exp_q.push_back({46'h0, e});
    repeat (8) @(negedge mclk);
    got_v = {46'h0, oe, line};
    -> got_ev;
  endtask
  // count mclk cycles between two toggles of data-out
  task automatic half_period();
    int n;
    logic p;
    n = 0;
    exp_q.push_back(48'(HC));
    for (int j = 0; j < 2; j++) begin
      n = 0;
      p = line;
      while (line === p && n < 200) begin
        @(negedge mclk);
        n++;
      end
    end
    got_v = 48'(n);
    -> got_ev;
  endtask
  task automatic tally_and_finish();
    num_errors += exp_q.size();  // notes whose result never appeared
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 26; i++) begin
      @(negedge mclk);
      gw = 1'b1;
      ga = i[4:0];
      gd = 8'(xs());
      mem[i] = gd;
    end
    @(negedge mclk) gw = 1'b0;
    write_config_cmd(1'b0);
    rdgrp(1'b1, 8'h02, 26, 6);
    rdgrp(1'b0, 8'h04, 0, 18);
    rdgrp(1'b1, 8'h06, 18, 3);
    rdgrp(1'b1, 8'h08, 21, 5);
    hdr(1'b1, 4'h6, 8'h02);
    rdb(8'hff);
    i_smcp_master.shut();
    foreach (codes[i]) begin
      if (codes[i][8]) exp_q.push_back({40'h0, codes[i][7:0]});
      hdr(1'b1, 4'h5, codes[i][7:0]);
      repeat (30) @(negedge mclk);
      i_smcp_master.shut();
    end
    $display("test conversion codes finished");
    hdr(1'b1, 4'h5, 8'h40);
    half_period();
    i_smcp_master.shut();
    sample(2'b01);
    top_of_stack_sel = 1'b0;
    hdr(1'b0, 4'h0, 8'h40);
    sample(2'b01);
    i_smcp_master.shut();
    $display("test toggle polls finished");
    write_config_cmd(1'b1);
    hold_busy = 1'b1;
    hdr(1'b1, 4'h5, 8'h40);
    sample(2'b10);
    hold_busy = 1'b0;
    sample(2'b01);
    i_smcp_master.shut();
    intr = 1'b1;
    hdr(1'b0, 4'h0, 8'h50);
    sample(2'b10);
    intr = 1'b0;
    sample(2'b01);
    i_smcp_master.shut();
    $display("test level polls finished");
    tally_and_finish();
  end
  // watchdog: several times the expected run length
  initial begin
    #(60000 * 40);
    num_errors++;
    $display("FAIL t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule // smcp_port_test
`default_nettype wire
